/* rtl/vct_clk_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module vct_clk_gen
   import vct_pkg::*;
#(
   parameter int unsigned CH_NUM = 2
)(
   input  wire logic                   ref_clk_i,     // master clock
   input  wire logic                   nrst_i,        // sync reset, active low
   input  wire logic [2:0]             rate_sel_i,    // bit clock rate code
   input  wire logic [CH_NUM-1:0][3:0] ch_div_i,      // per-channel divider
   output logic                        bclk_o,        // generated bit clock
   output logic [CH_NUM-1:0]           sample_tick_o  // one pulse per sample
);
   logic [7:0] div_cnt_reg;
   logic [7:0] div_cnt_next;
   logic       bclk_reg;
   logic       bclk_next;
   logic [7:0] half;

   // bit clock: toggles every half divisor; odd divisors are not used
   always_comb
   begin
      half         = vct_bclk_div(rate_sel_i) >> 1;   // R18 R19
      div_cnt_next = div_cnt_reg + 8'h01;
      bclk_next    = bclk_reg;
      if (div_cnt_next >= half)
      begin
         div_cnt_next = 8'h00;
         bclk_next    = ~bclk_reg;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         div_cnt_reg <= 8'h00;
         bclk_reg    <= 1'b0;
      end
      else
      begin
         div_cnt_reg <= div_cnt_next;
         bclk_reg    <= bclk_next;
      end
   end

   assign bclk_o = bclk_reg;

   // sample strobes: master clock over 512 times the channel divider
   genvar ch;
   generate
      for (ch = 0; ch < CH_NUM; ch++)
      begin : g_smp
         logic [SMP_CNT_W-1:0] cnt_reg;
         logic [SMP_CNT_W-1:0] cnt_next;
         logic                 tick_reg;
         logic                 tick_next;
         logic [SMP_CNT_W-1:0] limit;
         logic [3:0]           div;

         always_comb
         begin
            // a zero divider would wrap the limit, so treat it as one
            div       = (ch_div_i[ch] == 4'h0) ? 4'h1 : ch_div_i[ch];
            limit     = {div, 9'h000} - 13'h0001;         // R17
            tick_next = 1'b0;
            cnt_next  = cnt_reg + 13'h0001;
            if (cnt_reg >= limit)
            begin
               cnt_next  = 13'h0000;
               tick_next = 1'b1;
            end
         end

         always_ff @(posedge ref_clk_i)
         begin
            if (!nrst_i)
            begin
               cnt_reg  <= 13'h0000;
               tick_reg <= 1'b0;
            end
            else
            begin
               cnt_reg  <= cnt_next;
               tick_reg <= tick_next;
            end
         end

         assign sample_tick_o[ch] = tick_reg;
      end
   endgenerate
endmodule
`default_nettype wire

/* rtl/vct_tdm_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R01] flag enabled: data-valid flag sits in adc bit 15, sent first
// [R02] linear with flag: 15 data bits, msb at bit 14
// [R03] companded: code byte in bits 7..0, other non-flag bits zero
// [R04] two-bit coding field picks linear, a-law or mu-law
// [R05] linear without flag: full 16-bit sample, msb at bit 15
// [R06] companded without flag: upper byte zero, code in lower byte
// [R07] dac words decoded as 16-bit linear or low code byte by coding
// [R08] address pins pick slot pair 2/3, 4/5, 6/7 or 8/9
// [R09] first channel uses lower slot, second the following slot
// [R10] up to four devices share a port, eight data slots total
// [R11] master pin high: drive sync and bit clock; low: take them in
// [R12] system has exactly one master feeding every slave
// [R13] stand-alone slave source supplies a permitted clock set
// [R14] external bit clock, master clock and sync stay synchronous
// [R15] controller loads rate code and dividers before valid data
// [R16] sampling rate equals frame sync rate, 8 or 16 kHz
// [R17] sync is bit clock over 256; sample rate master clock over 512*I
// [R18] master bit clock divisor 12, 16, 6, 8 for codes 0..3
// [R19] reset defaults give 8 kHz from 24.576 MHz master clock
// [R20] frame of 256 bit clocks, sixteen 16-bit slots, sync marks start
// [R21] msb first, transmit on rising edge, receive on falling edge
// [R22] serial output driven only in own slots and control slots
module vct_tdm_port
   import vct_pkg::*;
#(
   parameter int unsigned CH_NUM = 2
)(
   input  wire logic                    ref_clk_i,         // master clock
   input  wire logic                    nrst_i,            // sync reset, active low
   input  wire logic                    master_sel_i,      // high: clock master
   input  wire logic                    addr_pin_hi_i,     // device address msb
   input  wire logic                    addr_pin_lo_i,     // device address lsb
   input  wire logic [2:0]              rate_sel_i,        // bit clock rate code
   input  wire logic [CH_NUM-1:0][3:0]  ch_div_i,          // sample dividers
   input  wire logic [1:0]              coding_sel_i,      // linear / mu / a-law
   input  wire logic                    dv_flag_en_i,      // data-valid flag on
   input  wire logic                    ctrl_slot_drive_i, // drive control slots
   input  wire vct_sample_type [CH_NUM-1:0] adc_sample_i,  // samples to send
   input  wire logic [CH_NUM-1:0]       adc_valid_i,       // conversion data valid
   input  wire logic                    bclk_i,            // bit clock pin in
   output logic                         bclk_o,            // bit clock pin out
   output logic                         bclk_oe_o,         // bit clock drive
   input  wire logic                    frame_sync_i,      // sync pin in
   output logic                         frame_sync_o,      // sync pin out
   output logic                         frame_sync_oe_o,   // sync drive
   input  wire logic                    sdin_i,            // serial data in
   output logic                         sdout_o,           // serial data out
   output logic                         sdout_oe_o,        // serial data drive
   output vct_sample_type [CH_NUM-1:0]  dac_sample_o,      // received samples
   output logic [CH_NUM-1:0]            dac_strobe_o,      // new dac word pulse
   output logic [CH_NUM-1:0]            sample_tick_o,     // sample rate strobes
   output logic                         locked_o           // frame sync found
);
   vct_state_type                 state_reg;
   vct_state_type                 state_next;
   logic                          bclk_prev_reg;
   logic                          bclk_prev_next;
   logic [7:0]                    cnt_reg;
   logic [7:0]                    cnt_next;
   logic                          fs_gen_reg;
   logic                          fs_gen_next;
   logic                          sd_reg;
   logic                          sd_next;
   logic                          sd_oe_reg;
   logic                          sd_oe_next;
   logic [15:0]                   rx_sr_reg;
   logic [15:0]                   rx_sr_next;
   logic [CH_NUM-1:0][15:0]       adc_word_reg;
   logic [CH_NUM-1:0][15:0]       adc_word_next;
   vct_sample_type [CH_NUM-1:0]   dac_reg;
   vct_sample_type [CH_NUM-1:0]   dac_next;
   logic [CH_NUM-1:0]             strobe_reg;
   logic [CH_NUM-1:0]             strobe_next;
   logic                          gen_bclk;
   logic                          bclk_cur;
   logic                          fs_cur;
   logic                          rise;
   logic                          fall;
   logic [1:0]                    addr;
   logic [1:0]                    tx_own;
   logic [1:0]                    rx_own;
   logic                          ctrl_slot;
   logic                          drive;
   logic [15:0]                   tx_word;

   // build one adc word from a sample and the current format settings
   function automatic logic [15:0] adc_format(input vct_sample_type s,
                                              input logic vld,
                                              input logic dv_en,
                                              input logic [1:0] code);
      logic [15:0] w;
      w = 16'h0000;
      if (code == CODE_LINEAR)                           // R04
      begin
         if (dv_en)
            w = {vld, s.lin[15:1]};                      // R01 R02
         else
            w = s.lin;                                   // R05
      end
      else
      begin
         w[PCM_MSB:0] = s.pcm;                           // R03 R06
         if (dv_en)
            w[FLAG_BIT] = vld;                           // R01
      end
      adc_format = w;
   endfunction

   // master clock divider and sample strobes
   vct_clk_gen #(
      .CH_NUM        (CH_NUM)
   ) u_clk_gen (
      .ref_clk_i     (ref_clk_i),
      .nrst_i        (nrst_i),
      .rate_sel_i    (rate_sel_i),
      .ch_div_i      (ch_div_i),
      .bclk_o        (gen_bclk),
      .sample_tick_o (sample_tick_o)
   );

   // pins are synchronous to the master clock, so no synchroniser is used;
   // a bit clock not derived from the master clock breaks this
   always_comb
   begin
      addr     = {addr_pin_hi_i, addr_pin_lo_i};
      bclk_cur = master_sel_i ? gen_bclk : bclk_i;       // R11 R14
      fs_cur   = master_sel_i ? fs_gen_reg : frame_sync_i;
      rise     = bclk_cur & ~bclk_prev_reg;
      fall     = ~bclk_cur & bclk_prev_reg;
      bclk_prev_next = bclk_cur;
   end

   // transmit side: bit counter, frame sync and serial out on rising edges
   always_comb
   begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      fs_gen_next   = fs_gen_reg;
      sd_next       = sd_reg;
      sd_oe_next    = sd_oe_reg;
      adc_word_next = adc_word_reg;
      tx_own        = 2'b00;
      ctrl_slot     = 1'b0;
      drive         = 1'b0;
      tx_word       = 16'h0000;
      if (rise)
      begin
         if (fs_cur)
         begin
            cnt_next   = 8'h00;                          // R20
            state_next = VCT_RUN;
            // latch all channels at once so a frame carries one sample set
            for (int c = 0; c < CH_NUM; c++)
               adc_word_next[c] = adc_format(adc_sample_i[c], adc_valid_i[c],
                                             dv_flag_en_i, coding_sel_i);
         end
         else
         begin
            cnt_next = cnt_reg + 8'h01;
         end
         // sync once per 256 bit clocks, so the sample rate is the frame rate
         fs_gen_next = (cnt_next == FRAME_SYNC_CNT);     // R16 R17
         tx_own    = vct_slot_owner(cnt_next[7:4], addr); // R08 R10
         ctrl_slot = (cnt_next[7:4] == CTRL_SLOT0) || (cnt_next[7:4] == CTRL_SLOT1);
         if (tx_own[0])
            tx_word = adc_word_next[0];                  // R09
         else if (tx_own[1])
            tx_word = adc_word_next[1];                  // R09
         drive = (state_next == VCT_RUN) &&
                 ((tx_own != 2'b00) || (ctrl_slot && ctrl_slot_drive_i)); // R22
         sd_oe_next = drive;                             // R22
         sd_next    = drive & tx_word[LAST_BIT - cnt_next[3:0]]; // R21
      end
   end

   // receive side: shift on falling edges, hand over at slot end
   always_comb
   begin
      rx_sr_next  = rx_sr_reg;
      dac_next    = dac_reg;
      strobe_next = '0;
      rx_own      = vct_slot_owner(cnt_reg[7:4], addr);  // R08 R09
      if (fall)
      begin
         rx_sr_next = {rx_sr_reg[14:0], sdin_i};         // R21
         if ((state_reg == VCT_RUN) && (cnt_reg[3:0] == LAST_BIT))
         begin
            for (int c = 0; c < CH_NUM; c++)
            begin
               if (rx_own[c])
               begin
                  // companded words use only the low byte, the rest is ignored
                  if (coding_sel_i == CODE_LINEAR)       // R07
                  begin
                     dac_next[c].lin = rx_sr_next;
                     dac_next[c].pcm = 8'h00;
                  end
                  else
                  begin
                     dac_next[c].lin = 16'h0000;
                     dac_next[c].pcm = rx_sr_next[PCM_MSB:0]; // R07
                  end
                  strobe_next[c] = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         state_reg     <= VCT_HUNT;
         bclk_prev_reg <= 1'b0;
         cnt_reg       <= 8'h00;
         fs_gen_reg    <= 1'b0;
         sd_reg        <= 1'b0;
         sd_oe_reg     <= 1'b0;
         rx_sr_reg     <= 16'h0000;
         adc_word_reg  <= '0;
         dac_reg       <= '0;
         strobe_reg    <= '0;
      end
      else
      begin
         state_reg     <= state_next;
         bclk_prev_reg <= bclk_prev_next;
         cnt_reg       <= cnt_next;
         fs_gen_reg    <= fs_gen_next;
         sd_reg        <= sd_next;
         sd_oe_reg     <= sd_oe_next;
         rx_sr_reg     <= rx_sr_next;
         adc_word_reg  <= adc_word_next;
         dac_reg       <= dac_next;
         strobe_reg    <= strobe_next;
      end
   end

   // clock pins are driven only as master
   assign bclk_o          = gen_bclk;
   assign bclk_oe_o       = master_sel_i;                // R11
   assign frame_sync_o    = fs_gen_reg;
   assign frame_sync_oe_o = master_sel_i;                // R11
   assign sdout_o         = sd_reg;
   assign sdout_oe_o      = sd_oe_reg;
   assign dac_sample_o    = dac_reg;
   assign dac_strobe_o    = strobe_reg;
   assign locked_o        = (state_reg == VCT_RUN);
endmodule
`default_nettype wire

/* shared/vct_pkg.sv */
`default_nettype none
package vct_pkg;
   // frame geometry: 16 slots of 16 bits
   localparam int unsigned FRAME_BITS = 256;
   localparam int unsigned SLOT_BITS  = 16;
   localparam logic [7:0]  FRAME_SYNC_CNT = 8'hff; // count at which sync is raised
   localparam logic [3:0]  LAST_BIT   = 4'hf;
   localparam logic [3:0]  CTRL_SLOT0 = 4'h0;
   localparam logic [3:0]  CTRL_SLOT1 = 4'h1;
   localparam logic [3:0]  SLOT_BASE  = 4'h2;    // first data slot of device 0
   // sample coding select, bits 7:6 of coding config
   localparam int unsigned CODE_FIELD_LSB = 6;
   localparam logic [1:0]  CODE_LINEAR    = 2'h0;
   localparam logic [1:0]  CODE_MULAW     = 2'h1;
   localparam logic [1:0]  CODE_ALAW      = 2'h2;
   // adc word layout
   localparam int unsigned FLAG_BIT   = 15;
   localparam int unsigned LIN_DV_MSB = 14;
   localparam int unsigned PCM_MSB    = 7;
   // rate select and bit clock divisors
   localparam logic [2:0] RATE_SEL_RST = 3'h0;
   localparam logic [7:0] BCLK_DIV_R0  = 8'h0c;
   localparam logic [7:0] BCLK_DIV_R1  = 8'h10;
   localparam logic [7:0] BCLK_DIV_R2  = 8'h06;
   localparam logic [7:0] BCLK_DIV_R3  = 8'h08;
   // per-channel sample divider
   localparam logic [3:0]  CH_DIV_RST  = 4'h6;
   localparam int unsigned SMP_SHIFT   = 9;       // times 512
   localparam int unsigned SMP_CNT_W   = 13;

   typedef struct packed {
      logic [15:0] lin;
      logic [7:0]  pcm;
   } vct_sample_type;

   typedef enum logic [1:0] {
      VCT_HUNT = 2'b01,
      VCT_RUN  = 2'b10
   } vct_state_type;

   // master clock divisor for the bit clock
   function automatic logic [7:0] vct_bclk_div(input logic [2:0] rate);
      case (rate)
         3'h0:    vct_bclk_div = BCLK_DIV_R0;
         3'h1:    vct_bclk_div = BCLK_DIV_R1;
         3'h2:    vct_bclk_div = BCLK_DIV_R2;
         3'h3:    vct_bclk_div = BCLK_DIV_R3;
         default: vct_bclk_div = BCLK_DIV_R0;
      endcase
   endfunction

   // which codec channel owns a slot: bit0 first, bit1 second
   function automatic logic [1:0] vct_slot_owner(input logic [3:0] slot,
                                                 input logic [1:0] addr);
      logic [3:0] base;
      base = SLOT_BASE + {1'b0, addr, 1'b0};
      if (slot == base)
         vct_slot_owner = 2'b01;
      else if (slot == base + 4'h1)
         vct_slot_owner = 2'b10;
      else
         vct_slot_owner = 2'b00;
   endfunction
endpackage
`default_nettype wire

/* test/vct_dsp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vct_dsp_model
   import vct_pkg::*;
(
   input  wire logic              ref_clk_i,  // master clock
   input  wire logic              bclk_i,     // bit clock line
   input  wire logic              frame_sync_i, // sync line
   input  wire logic              sdout_i,    // device data
   input  wire logic              sdout_oe_i, // device drive
   input  wire logic [15:0][15:0] tx_i,       // words per slot
   output logic                   bclk_o,     // source bit clock
   output logic                   frame_sync_o, // source sync
   output logic                   sdin_o,     // data to device
   output logic [15:0][15:0]      rx_o,       // words seen
   output logic [15:0][15:0]      rx_oe_o     // drive seen
);
   logic [2:0] div_reg;
   logic [7:0] gen_cnt;
   logic [7:0] cnt;
   initial
   begin
      div_reg = 3'h0;
      gen_cnt = 8'h00;
      cnt = 8'h00;
      bclk_o = 1'b0;
      frame_sync_o = 1'b0;
      sdin_o = 1'b0;
   end
   // source clocks derived from the master clock so all stay synchronous
   always @(posedge ref_clk_i)
   begin
      div_reg <= (div_reg == 3'h5) ? 3'h0 : div_reg + 3'h1;
      if (div_reg == 3'h5)
      begin
         bclk_o <= ~bclk_o;
         if (!bclk_o)
            gen_cnt <= gen_cnt + 8'h01;
         else
            frame_sync_o <= (gen_cnt == 8'hff);
      end
   end
   // send on rising edge, msb first, slot position from sync
   always @(posedge bclk_i)
   begin
      cnt = (frame_sync_i === 1'b1) ? 8'h00 : cnt + 8'h01;
      #1;
      sdin_o = tx_i[cnt[7:4]][~cnt[3:0]];
   end
   // capture on falling edge
   always @(negedge bclk_i)
   begin
      rx_o[cnt[7:4]][~cnt[3:0]] <= sdout_i;
      rx_oe_o[cnt[7:4]][~cnt[3:0]] <= sdout_oe_i;
   end
endmodule
`default_nettype wire

/* test/vct_tdm_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module vct_tdm_properties
   import vct_pkg::*;
#(
   parameter int unsigned CH_NUM = 2
)(
   input wire logic              ref_clk_i,       // clock
   input wire logic              nrst_i,          // reset
   input wire logic              master_sel_i,    // master pin
   input wire logic [2:0]        rate_sel_i,      // rate code
   input wire logic              bclk_o,          // bit clock
   input wire logic              bclk_oe_o,       // its drive
   input wire logic              frame_sync_o,    // sync
   input wire logic              frame_sync_oe_o, // its drive
   input wire logic              sdout_o,         // data out
   input wire logic              sdout_oe_o,      // its drive
   input wire logic [CH_NUM-1:0] dac_strobe_o,    // dac pulses
   input wire logic [CH_NUM-1:0] sample_tick_o,   // ticks
   input wire logic              locked_o         // sync found
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // code 0 high phase is six clocks; any drift skews every slot
   sequence s_half_code0;
      bclk_o [*6] ##1 !bclk_o;
   endsequence
   // sync spans one bit period, 6 to 16 clocks by code
   sequence s_sync_bit;
      frame_sync_o [*6] ##[1:11] !frame_sync_o;
   endsequence
   a_bclk_pin_dir: assert property (bclk_oe_o == master_sel_i)
      else $error("bit clock drive differs from master pin");
   a_sync_pin_dir: assert property (frame_sync_oe_o == master_sel_i)
      else $error("sync drive differs from master pin");
   a_bclk_half_period: assert property (
      master_sel_i && rate_sel_i == 3'h0 && $rose(bclk_o) |-> s_half_code0)
      else $error("bit clock half period wrong");
   a_sync_frame_start: assert property (
      master_sel_i && $rose(frame_sync_o) |-> s_sync_bit)
      else $error("sync pulse width wrong");
   a_sdout_idle_low: assert property (!sdout_oe_o |-> !sdout_o)
      else $error("data out not low while released");
   a_hunt_silent: assert property (!locked_o |-> !sdout_oe_o && !dac_strobe_o)
      else $error("activity before sync found");
   a_strobe_single: assert property (
      dac_strobe_o[0] |-> locked_o ##1 (!dac_strobe_o[0]) [*8])
      else $error("dac strobe not a single pulse");
   a_tick_single: assert property (sample_tick_o[0] |=> (!sample_tick_o[0]) [*8])
      else $error("sample tick not a single pulse");
endmodule
bind vct_tdm_port vct_tdm_properties #(.CH_NUM(CH_NUM)) u_props (
   .ref_clk_i, .nrst_i, .master_sel_i, .rate_sel_i, .bclk_o, .bclk_oe_o, .frame_sync_o,
   .frame_sync_oe_o, .sdout_o, .sdout_oe_o, .dac_strobe_o, .sample_tick_o, .locked_o
);
`default_nettype wire

/* test/voice_codec_tdm_data_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module voice_codec_tdm_data_port_bench;
   import vct_pkg::*;
   logic                 ref_clk_i, nrst_i, master_sel_i, dv_en, ctrl_drv;
   logic [1:0]           addr, coding, adc_valid, dac_strobe, tick;
   logic [2:0]           rate;
   logic [1:0][3:0]      ch_div;
   vct_sample_type [1:0] adc, dac;
   logic [15:0][15:0]    tx_w, rx_w, rx_oe;
   logic                 bclk_dut, bclk_dsp, bclk_oe, bclk_ln;
   logic                 sync_dut, sync_dsp, sync_oe, sync_ln;
   logic                 sdin, sdout, sdout_oe, locked;
   int                   num_errors, tests_run, div_now;
   // pin level from whichever party enables its driver
   assign bclk_ln = bclk_oe ? bclk_dut : bclk_dsp;
   assign sync_ln = sync_oe ? sync_dut : sync_dsp;
   vct_tdm_port #(.CH_NUM(2)) DUT (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .master_sel_i(master_sel_i),
      .addr_pin_hi_i(addr[1]), .addr_pin_lo_i(addr[0]), .rate_sel_i(rate),
      .ch_div_i(ch_div), .coding_sel_i(coding), .dv_flag_en_i(dv_en),
      .ctrl_slot_drive_i(ctrl_drv), .adc_sample_i(adc), .adc_valid_i(adc_valid),
      .bclk_i(bclk_ln), .bclk_o(bclk_dut), .bclk_oe_o(bclk_oe),
      .frame_sync_i(sync_ln), .frame_sync_o(sync_dut), .frame_sync_oe_o(sync_oe),
      .sdin_i(sdin), .sdout_o(sdout), .sdout_oe_o(sdout_oe), .dac_sample_o(dac),
      .dac_strobe_o(dac_strobe), .sample_tick_o(tick), .locked_o(locked));
   vct_dsp_model u_dsp (
      .ref_clk_i(ref_clk_i), .bclk_i(bclk_ln), .frame_sync_i(sync_ln), .sdout_i(sdout),
      .sdout_oe_i(sdout_oe), .tx_i(tx_w), .bclk_o(bclk_dsp), .frame_sync_o(sync_dsp),
      .sdin_o(sdin), .rx_o(rx_w), .rx_oe_o(rx_oe));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic report(input logic ok, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (!ok)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      report(got === exp, {16'h0000, got}, {16'h0000, exp});
   endtask
   task automatic cmp_sample(input vct_sample_type got, input vct_sample_type exp);
      report(got === exp, {8'h00, got}, {8'h00, exp});
   endtask
   task automatic cmp_count(input int got, input int exp);
      report(got == exp, got, exp);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   function automatic logic [15:0] adc_exp(input vct_sample_type s, input logic v,
                                           input logic f, input logic [1:0] c);
      if (c == CODE_LINEAR)
         return f ? {v, s.lin[15:1]} : s.lin;
      return f ? {v, 7'h00, s.pcm} : {8'h00, s.pcm};
   endfunction
   function automatic logic pick(input int k);
      return (k == 0) ? sync_dut : tick[k-1];
   endfunction
   // cycles from now to the next rising edge of the chosen output
   task automatic gap(input int k, output int n);
      logic prev;
      n = 0;
      prev = 1'b1;
      while (!(pick(k) === 1'b1 && prev === 1'b0) && n < 9000)
      begin
         prev = pick(k);
         step(1);
         n++;
      end
   endtask
   task automatic restart(input logic [2:0] r, input logic m, input int d);
      nrst_i = 1'b0;
      rate = r;
      master_sel_i = m;
      div_now = d;
      step(2);
      nrst_i = 1'b1;
      step(256 * d);
   endtask
   task automatic check_formats();
      logic [1:0] c;
      for (int i = 0; i < 6; i++)
      begin
         c = (i < 2) ? CODE_LINEAR : ((i < 4) ? CODE_MULAW : CODE_ALAW);
         coding = c;
         dv_en = i[0];
         step(2 * 256 * div_now);
         for (int k = 0; k < 2; k++)
            cmp_word(rx_w[2+k], adc_exp(adc[k], adc_valid[k], i[0], c));
      end
   endtask
   task automatic check_slots();
      logic [15:0] e;
      for (int a = 0; a < 4; a++)
      begin
         addr = a[1:0];
         ctrl_drv = a[0];
         step(2 * 256 * div_now);
         for (int s = 0; s < 16; s++)
         begin
            e = (s == 2 + 2 * a || s == 3 + 2 * a || (a[0] && s < 2)) ? 16'hffff : 16'h0000;
            cmp_word(rx_oe[s], e);
         end
         cmp_word(rx_w[3+2*a], adc_exp(adc[1], adc_valid[1], dv_en, coding));
         if (a[0])
            cmp_word(rx_w[1], 16'h0000);
      end
   endtask
   task automatic check_dac();
      addr = 2'h0;
      for (int k = 0; k < 2; k++)
      begin
         coding = k ? CODE_ALAW : CODE_LINEAR;
         // companded words carry a zero upper byte from the processor
         tx_w[2] = k ? 16'h003e : 16'h9c3e;
         tx_w[3] = k ? 16'h00f0 : 16'h61f0;
         step(2 * 256 * div_now);
         for (int c = 0; c < 2; c++)
            cmp_sample(dac[c], k ? {16'h0000, tx_w[2+c][7:0]} : {tx_w[2+c], 8'h00});
      end
   endtask
   task automatic check_rates();
      int n;
      int divs [4];
      divs = '{12, 16, 6, 8};
      for (int r = 0; r < 4; r++)
      begin
         restart(r[2:0], 1'b1, divs[r]);
         gap(0, n);
         gap(0, n);
         cmp_count(n, 256 * divs[r]);
      end
      gap(1, n);
      gap(1, n);
      cmp_count(n, 512 * 6);
      gap(2, n);
      gap(2, n);
      cmp_count(n, 512 * 3);
   endtask
   task automatic check_slave();
      coding = CODE_LINEAR;
      dv_en = 1'b0;
      restart(RATE_SEL_RST, 1'b0, 12);
      step(2 * 256 * 12);
      cmp_word({14'h0000, bclk_oe, sync_oe}, 16'h0000);
      cmp_word({15'h0000, locked}, 16'h0001);
      cmp_word(rx_w[2], adc[0].lin);
      cmp_sample(dac[1], {tx_w[3], 8'h00});
   endtask
   initial
   begin
      // tests need about 90k clocks; stop at 100k
      #800000;
      num_errors++;
      complete_run();
   end
   initial
   begin
      num_errors = 0;
      tests_run = 0;
      nrst_i = 1'b0;
      master_sel_i = 1'b1;
      addr = 2'h0;
      rate = 3'h2;
      div_now = 6;
      ch_div = {4'h3, CH_DIV_RST};
      coding = CODE_LINEAR;
      dv_en = 1'b0;
      ctrl_drv = 1'b0;
      adc[0] = {16'hb5a3, 8'hc7};
      adc[1] = {16'h4e1d, 8'h39};
      adc_valid = 2'b10;
      for (int s = 0; s < 16; s++)
         tx_w[s] = 16'ha5a5 ^ 16'(s);
      repeat (12) @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b1;
      step(256 * 6);
      check_formats();
      check_slots();
      check_dac();
      check_rates();
      check_slave();
      complete_run();
   end
endmodule
`default_nettype wire
